/* File: sadc_pkg.sv */
// Purpose: Shared constants for the converter sequencing and power-down block.
// Assumes: A 50 MHz system clock.
// Notes:   Times are kept in nanoseconds and turned into cycle counts here.
package sadc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 20;
    localparam int PWRUP_TIME_NS   = 1500;
    localparam int CONV_TIME_NS    = 4500;
    localparam int SETTLE_TIME_NS  = 100;
    // Least times round up to whole cycles.
    localparam int PWRUP_CYCLES  = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Data format
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 8;
    localparam int CNT_BITS    = 9;

    typedef enum logic [1:0] {
        SADC_OFF,
        SADC_IDLE,
        SADC_CONV
    } sadc_state_e;

endpackage

/* File: sadc_sar.sv */
// Purpose: Successive-approximation search over an 8-bit trial code.
// Assumes: The comparator answer is valid one cycle after each trial code.
// Notes:   One bit is resolved per step; done pulses when all are decided.
`timescale 1ns/1ps
`default_nettype none
module sadc_sar
    import sadc_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Control
    input  wire logic             start,
    input  wire logic             step,
    input  wire logic             comp_high,
    // Results
    output logic [WIDTH-1:0]      trial,
    output logic                  done
);

    logic [WIDTH-1:0] bit_mask;

    // ------------------------------------------------------------
    // Trial search
    // ------------------------------------------------------------
    // Adjust until balanced.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trial    <= '0;
            bit_mask <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                trial    <= {1'b1, {(WIDTH-1){1'b0}}};
                bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (step && bit_mask != '0) begin
                if (comp_high) begin
                    trial <= (trial & ~bit_mask) | (bit_mask >> 1);
                end else begin
                    trial <= trial | (bit_mask >> 1);
                end
                bit_mask <= bit_mask >> 1;
                if (bit_mask[0]) begin
                    done <= 1'b1;
                end
            end
        end
    end

endmodule // sadc_sar
`default_nettype wire

/* File: sadc_ctrl.sv */
// Purpose: Convert-start sequencing, power-down control and result port.
// Assumes: Pins are synchronous to CLK; the analog side answers a compare.
// Notes:   The data bus is split into output, enable and no input.
//
// Functional notes
// - Falling convert-start raises busy for the conversion.
// - Busy falls at end of conversion.
// - After reset the core is powered down.
// - Rising convert-start wakes the core.
// - No conversion starts while powered down.
// - Each rising convert-start launches a 1.5 us internal pulse.
// - Conversion starts on the falling edge of gated convert-start.
// - Acquisition runs from end of conversion to convert-start fall.
// - Sampler settles about 100 ns after each conversion.
// - Search adjusts trial code until comparator balances.
// - Result is straight binary, step is reference over 256.
// - Code transitions at integer multiples of one step.
// - Automatic mode powers down after each conversion.
// - Conversion lasts 4.5 us; power-up plus conversion 6 us.
// - Gated convert-start is OR of external and internal.
// - Convert-start level when busy falls picks the mode.
// - Result latched at end; bus driven when select and read low.
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int PWRUP_CNT  = PWRUP_CYCLES,
    parameter int CONV_CNT   = CONV_CYCLES,
    parameter int SETTLE_CNT = SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RESET,
    // Host control
    input  wire logic                   CONV_START_N,
    input  wire logic                   CS_N,
    input  wire logic                   RD_N,
    // Analog side
    input  wire logic                   COMP_HIGH,
    output logic [RESULT_BITS-1:0]      TRIAL_CODE,
    output logic                        SAMPLE_HOLD,
    output logic                        POWERED,
    output logic                        SETTLING,
    // Status and data
    output logic                        BUSY,
    output logic [RESULT_BITS-1:0]      RESULT_BUS_O,
    output logic                        RESULT_BUS_OE
);

    sadc_state_e            state;
    logic                   ext_q;
    logic                   int_pulse;
    logic                   gated_q;
    logic [CNT_BITS-1:0]    pulse_cnt;
    logic [CNT_BITS-1:0]    conv_cnt;
    logic [CNT_BITS-1:0]    settle_cnt;
    logic [RESULT_BITS-1:0] result_reg;
    logic                   read_ok;
    logic                   sar_start;
    logic                   sar_done;
    logic [RESULT_BITS-1:0] sar_trial;
    logic                   ext_rise;
    logic                   gated;
    logic                   gated_fall;
    logic                   conv_end;
    logic                   step_phase;
    logic                   sar_step;
    logic [RESULT_BITS-1:0] search_code;

    assign ext_rise   = CONV_START_N & ~ext_q;
    assign gated      = CONV_START_N | int_pulse;
    assign gated_fall = gated_q & ~gated;
    assign conv_end   = (state == SADC_CONV) &&
                        (conv_cnt == CNT_BITS'(CONV_CNT - 1));
    assign sar_start  = gated_fall && (state == SADC_IDLE);
    assign sar_step   = (state == SADC_CONV) && step_phase;

    // ------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ext_q   <= 1'b0;
            gated_q <= 1'b0;
        end else begin
            ext_q   <= CONV_START_N;
            gated_q <= gated;
        end
    end

    // ------------------------------------------------------------
    // Internal power-up pulse
    // ------------------------------------------------------------
    // Timed 1.5 us pulse.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            int_pulse <= 1'b0;
            pulse_cnt <= '0;
        end else if (ext_rise) begin
            int_pulse <= 1'b1;
            pulse_cnt <= '0;
        end else if (int_pulse) begin
            if (pulse_cnt == CNT_BITS'(PWRUP_CNT - 1)) begin
                int_pulse <= 1'b0;
            end
            pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power and conversion state
    // ------------------------------------------------------------
    // Power sequencing.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state <= SADC_OFF;
        end else begin
            case (state)
                SADC_OFF: begin
                    if (ext_rise) begin
                        state <= SADC_IDLE;
                    end
                end
                SADC_IDLE: begin
                    if (sar_start) begin
                        state <= SADC_CONV;
                    end
                end
                SADC_CONV: begin
                    if (conv_end) begin
                        state <= CONV_START_N ? SADC_IDLE : SADC_OFF;
                    end
                end
                default: begin
                    state <= SADC_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            conv_cnt <= '0;
        end else if (state == SADC_CONV) begin
            conv_cnt <= conv_cnt + 1'b1;
        end else begin
            conv_cnt <= '0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            BUSY <= 1'b0;
        end else if (sar_start) begin
            BUSY <= 1'b1;
        end else if (conv_end) begin
            BUSY <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            SAMPLE_HOLD <= 1'b0;
            SETTLING    <= 1'b0;
            settle_cnt  <= '0;
        end else begin
            if (sar_start) begin
                SAMPLE_HOLD <= 1'b1;
            end else if (conv_end) begin
                SAMPLE_HOLD <= 1'b0;
            end
            if (conv_end) begin
                SETTLING   <= 1'b1;
                settle_cnt <= '0;
            end else if (SETTLING) begin
                if (settle_cnt == CNT_BITS'(SETTLE_CNT - 1)) begin
                    SETTLING <= 1'b0;
                end
                settle_cnt <= settle_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            POWERED    <= 1'b0;
            TRIAL_CODE <= '0;
        end else begin
            POWERED    <= ext_rise ||
                          ((state != SADC_OFF) &&
                           !(conv_end && !CONV_START_N));
            TRIAL_CODE <= sar_trial;
        end
    end

    // ------------------------------------------------------------
    // Search engine
    // ------------------------------------------------------------
    // Step every second cycle.
    // The trial code reaches the comparator one cycle late, so the
    // engine waits for the answer that belongs to its current code.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            step_phase <= 1'b0;
        end else if (state == SADC_CONV) begin
            step_phase <= ~step_phase;
        end else begin
            step_phase <= 1'b0;
        end
    end

    sadc_sar #(
        .WIDTH      (RESULT_BITS)
    ) u_sar (
        .clk        (CLK),
        .reset      (RESET),
        .start      (sar_start),
        .step       (sar_step),
        .comp_high  (COMP_HIGH),
        .trial      (sar_trial),
        .done       (sar_done)
    );

    // ------------------------------------------------------------
    // Result register and read port
    // ------------------------------------------------------------
    // Latch binary code.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            search_code <= '0;
            result_reg  <= '0;
        end else begin
            if (sar_done) begin
                search_code <= sar_trial;
            end
            if (conv_end) begin
                result_reg <= search_code;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            read_ok <= 1'b0;
        end else if (sar_start) begin
            read_ok <= 1'b0;
        end else if (conv_end) begin
            read_ok <= 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            RESULT_BUS_O  <= '0;
            RESULT_BUS_OE <= 1'b0;
        end else begin
            RESULT_BUS_OE <= ~CS_N & ~RD_N;
            RESULT_BUS_O  <= read_ok ? result_reg : '0;
        end
    end

endmodule // sadc_ctrl
`default_nettype wire

/* File: sadc_afe_model.sv */
// Purpose: Comparator model for the analog side of the converter.
// Assumes: The input level is given in whole steps of reference/256.
// Notes:   Answers at once from the registered trial code.
`timescale 1ns/1ps
`default_nettype none
module sadc_afe_model
    import sadc_pkg::*;
(
    // Analog side
    input  wire logic [RESULT_BITS-1:0] trial_code,
    input  wire logic [RESULT_BITS-1:0] level,
    output logic                        comp_high
);
    // Trip points sit on whole steps.
    assign comp_high = (trial_code > level);
endmodule // sadc_afe_model
`default_nettype wire

/* File: sadc_ctrl_chk.sv */
// Purpose: Port timing checks for the convert-start sequencing block.
// Assumes: Counts equal those of the checked instance.
// Notes:   Attached by bind from the testbench.
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_chk
    import sadc_pkg::*;
#(
    parameter int PWRUP_CNT  = PWRUP_CYCLES,
    parameter int CONV_CNT   = CONV_CYCLES,
    parameter int SETTLE_CNT = SETTLE_CYCLES
) (
    // Watched ports
    input wire logic                   CLK,
    input wire logic                   RESET,
    input wire logic                   CONV_START_N,
    input wire logic                   CS_N,
    input wire logic                   RD_N,
    input wire logic                   SAMPLE_HOLD,
    input wire logic                   POWERED,
    input wire logic                   SETTLING,
    input wire logic                   BUSY,
    input wire logic [RESULT_BITS-1:0] RESULT_BUS_O,
    input wire logic                   RESULT_BUS_OE
);
    logic [8:0] bcnt;
    logic [8:0] scnt;
    logic [8:0] pcnt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // Counts busy cycles, settle cycles and cycles since a wake edge.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bcnt <= '0;
            scnt <= '0;
            pcnt <= '0;
        end else begin
            bcnt <= BUSY ? bcnt + 9'h1 : 9'h0;
            scnt <= SETTLING ? scnt + 9'h1 : 9'h0;
            if ($rose(CONV_START_N))
                pcnt <= 9'h1;
            else if (pcnt != 9'h1ff)
                pcnt <= pcnt + 9'h1;
        end
    end
    sequence conv_end_s;
        $fell(BUSY);
    endsequence
    sequence track_s;
        SETTLING && !SAMPLE_HOLD;
    endsequence
    pwr_first_a: assert property ($rose(BUSY) |-> POWERED)
        else $error("conversion began while powered down");
    pulse_wait_a: assert property ($rose(BUSY) |-> pcnt >= PWRUP_CNT)
        else $error("conversion began inside the wake pulse");
    wake_up_a: assert property ($rose(CONV_START_N) |-> ##[1:2] POWERED)
        else $error("rising convert-start did not wake the core");
    sample_hold_a: assert property ($rose(BUSY) |-> SAMPLE_HOLD)
        else $error("sampler not in hold at busy rise");
    conv_len_a: assert property (conv_end_s |-> bcnt == CONV_CNT)
        else $error("busy length differs from conversion count");
    end_track_a: assert property (conv_end_s |-> track_s)
        else $error("sampler did not return to track");
    settle_len_a: assert property ($fell(SETTLING) |-> scnt == SETTLE_CNT)
        else $error("settle length wrong");
    mode_pick_a: assert property (conv_end_s |-> POWERED == $past(CONV_START_N))
        else $error("power mode not set by convert-start level");
    bus_oe_a: assert property (RESULT_BUS_OE |-> ($past(CS_N) == 1'b0) && ($past(RD_N) == 1'b0))
        else $error("bus driven without select and read");
    bus_read_a: assert property (!CS_N && !RD_N |=> RESULT_BUS_OE)
        else $error("bus not driven on select and read");
    busy_clr_a: assert property ($rose(BUSY) |-> ##[0:1] RESULT_BUS_O == '0)
        else $error("read port not cleared at busy rise");
endmodule // sadc_ctrl_chk
`default_nettype wire

/* File: tb_sar_adc_conversion_powerdown_ctrl.sv */
// Purpose: Self-checking bench for the convert-start sequencing block.
// Assumes: Short counts 4, 20 and 2 cycles for speed.
// Notes:   Each conversion reads its result back over the port.
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_conversion_powerdown_ctrl;
    import sadc_pkg::*;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       conv_start_n = 1'b0;
    logic       cs_n = 1'b1;
    logic       rd_n = 1'b1;
    logic [7:0] level = 8'h00;
    logic       comp_high;
    logic [7:0] trial_code;
    logic       powered;
    logic       busy;
    logic [7:0] res_o;
    logic       res_oe;
    int         n_mismatch = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    always #10 clk = ~clk;
    sadc_ctrl #(.PWRUP_CNT(4), .CONV_CNT(20), .SETTLE_CNT(2)) uut (
        .CLK(clk), .RESET(reset), .CONV_START_N(conv_start_n),
        .CS_N(cs_n), .RD_N(rd_n), .COMP_HIGH(comp_high),
        .TRIAL_CODE(trial_code), .SAMPLE_HOLD(), .POWERED(powered),
        .SETTLING(), .BUSY(busy), .RESULT_BUS_O(res_o),
        .RESULT_BUS_OE(res_oe));
    sadc_afe_model afe (.trial_code(trial_code), .level(level),
        .comp_high(comp_high));
    task conclude;
        $display("compared %0d, mismatched %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wait_busy(input logic v);
        int i;
        i = 0;
        while (busy !== v && i < 100) begin
            @(posedge clk);
            #1;
            i++;
        end
        check("busy", {7'h0, v}, {7'h0, busy});
    endtask
    task t_reset;
        check("powered", 8'h00, {7'h0, powered});
        repeat (10) @(posedge clk);
        #1;
        check("busy", 8'h00, {7'h0, busy});
        $display("test reset done");
    endtask
    task t_conv(input logic [7:0] v, input int hold, input logic stay);
        @(posedge clk);
        level <= v;
        if (conv_start_n === 1'b0) conv_start_n <= 1'b1;
        repeat (hold) @(posedge clk);
        conv_start_n <= 1'b0;
        wait_busy(1'b1);
        check("powered", 8'h01, {7'h0, powered});
        if (stay) begin
            @(posedge clk);
            conv_start_n <= 1'b1;
        end
        wait_busy(1'b0);
        check("powered", {7'h0, stay}, {7'h0, powered});
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        @(posedge clk);
        #1;
        check("bus_oe", 8'h01, {7'h0, res_oe});
        check("result", v, res_o);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk);
        #1;
        check("bus_oe", 8'h00, {7'h0, res_oe});
        repeat (4) @(posedge clk);
        $display("test conv %h done", v);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_conv(8'h00, 1, 1'b0);
        t_conv(8'hff, 8, 1'b0);
        t_conv(8'h80, 1, 1'b1);
        t_conv(8'h7f, 3, 1'b0);
        t_conv(8'h55, 2, 1'b0);
        conclude();
    end
endmodule // tb_sar_adc_conversion_powerdown_ctrl
bind sadc_ctrl sadc_ctrl_chk #(.PWRUP_CNT(PWRUP_CNT), .CONV_CNT(CONV_CNT),
    .SETTLE_CNT(SETTLE_CNT)) chk (.CLK(CLK), .RESET(RESET),
    .CONV_START_N(CONV_START_N), .CS_N(CS_N), .RD_N(RD_N),
    .SAMPLE_HOLD(SAMPLE_HOLD), .POWERED(POWERED), .SETTLING(SETTLING),
    .BUSY(BUSY), .RESULT_BUS_O(RESULT_BUS_O), .RESULT_BUS_OE(RESULT_BUS_OE));
`default_nettype wire
